// [fspc_buf_mem.sv]
`timescale 1ns/1ps
module fspc_buf_mem
	import fspc_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 64,
	parameter int AW    = 6
)(
	input  wire logic             pclk,
	input  wire logic             ce,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_q
);

	logic [WIDTH-1:0] mem [DEPTH];   // Temporary page buffer words

	// Write port; no reset, contents are qualified by valid bits outside
	always_ff @(posedge pclk)
	begin
		if (ce && wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge pclk)
	begin
		if (ce)
		begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule

// [fspc_cpu_model.sv]
`timescale 1ns/1ps
// Core stand-in: issues one-cycle store or load instructions on request
module fspc_cpu_model
	import fspc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic cpu_halt,
	output fspc_cpu_s cpu
);
	// Pointer, pair and code page are register levels; strobes idle low
	initial cpu = '0;

	// Instruction is sampled at the gap-th edge after the call edge
	task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d,
		input logic [6:0] pg, input int gap);
		cpu.z_addr         <= z;
		cpu.data_word_pair <= d;
		cpu.pc_page        <= pg;
		repeat (gap - 1) @(posedge pclk);
		// A halted core fetches nothing, so it cannot issue either
		if (cpu_halt !== 1'b1)
		begin
			cpu.spm <= st;
			cpu.lpm <= !st;
		end
		@(posedge pclk);
		cpu.spm <= 1'b0;
		cpu.lpm <= 1'b0;
	endtask
endmodule

// [fspc_pkg.sv]
package fspc_pkg;

	// Control/status register index counts words, so byte address is four times it
	localparam logic [9:0]  CSR_INDEX       = 10'h037;
	localparam logic [11:0] CSR_ADDR        = {CSR_INDEX, 2'b00};
	localparam logic [7:0]  CSR_RESET       = 8'h00;

	// Bit positions inside the control/status register
	localparam int          BIT_IRQ_EN      = 7;
	localparam int          BIT_BUSY        = 6;
	localparam int          BIT_RSVD        = 5;
	localparam int          BIT_REEN        = 4;
	localparam int          BIT_FUSE        = 3;
	localparam int          BIT_PAGE_WRITE_CMD       = 2;
	localparam int          BIT_PAGE_ERASE_CMD       = 1;
	localparam int          BIT_EN          = 0;

	// Command patterns in the low five bits: five legal ones, then the cleared value
	localparam logic [4:0]  CMD_REEN        = 5'h11;
	localparam logic [4:0]  CMD_FUSE        = 5'h09;
	localparam logic [4:0]  CMD_PAGE_WRITE_CMD       = 5'h05;
	localparam logic [4:0]  CMD_PAGE_ERASE_CMD       = 5'h03;
	localparam logic [4:0]  CMD_FILL        = 5'h01;
	localparam logic [4:0]  CMD_NONE        = 5'h00;

	// Command windows in cycles after the register write
	localparam logic [2:0]  WIN_SPM         = 3'h4;
	localparam logic [2:0]  WIN_LPM_MIN     = 3'h2;
	localparam logic [2:0]  WIN_LAST        = 3'h1;

	// Flash geometry: 128 pages of 64 words
	localparam int          PAGE_WORDS      = 64;
	localparam int          WORD_W          = 16;
	localparam logic [6:0]  HALTING_SECTION_START_PAGE = 7'h70;
	localparam logic [6:0]  BOOT_PAGE_SZ0   = 7'h70;
	localparam logic [6:0]  BOOT_PAGE_SZ1   = 7'h78;
	localparam logic [6:0]  BOOT_PAGE_SZ2   = 7'h7C;
	localparam logic [6:0]  BOOT_PAGE_SZ3   = 7'h7E;
	localparam logic [15:0] ERASED_WORD     = 16'hFFFF;

	// Lock byte bits that inhibit self-programming writes, per section
	localparam int          LOCK_APP_WR     = 2;
	localparam int          LOCK_BOOT_WR    = 4;

	// Programming time, least figure, rounded up to whole cycles
	localparam int          CLK_PERIOD_NS   = 25;
	localparam int          PROG_TIME_NS    = 3700000;
	localparam int          PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_PROG} fspc_state_e;

	// Instruction events from the CPU core
	typedef struct packed {
		logic        spm;        // Store-program instruction, one cycle
		logic        lpm;        // Load-program instruction, one cycle
		logic [15:0] z_addr;     // Byte address pointer
		logic [15:0] data_word_pair;
		logic [6:0]  pc_page;    // Page the executing code sits in
	} fspc_cpu_s;

	// Fuse and lock bytes, one means programmed
	typedef struct packed {
		logic [7:0] fuse_low;
		logic [7:0] fuse_high;
		logic [7:0] fuse_ext;
		logic [7:0] lock;
	} fspc_fuse_s;

	// Command stream to the flash array
	typedef struct packed {
		logic        erase;      // One-cycle start of page erase
		logic        wr_valid;   // One word of a page write
		logic [6:0]  page;
		logic [5:0]  word;
		logic [15:0] data;
	} fspc_flash_s;

endpackage

// [fspc_top.sv]
// Summary of operation
// R1 - Ready irq needs enable, global flag, idle
// R2 - No ready irq during EEPROM write, programming
// R3 - Busy bit high while concurrent section blocked
// R4 - Software re-enables section before reading it
// R5 - Re-enable write clears temporary page buffer
// R6 - Fuse read load returns fuse/lock bytes
// R7 - Page write command stores buffer to page
// R8 - Page write bit clears at end/timeout
// R9 - Page erase command erases addressed page
// R10 - Page erase bit clears at end/timeout
// R11 - Enable alone stores word into buffer
// R12 - Enable clears after store, holds during op
// R13 - Only five command patterns take effect
// R14 - Bit five always reads zero
// R15 - Stores start programming only from boot
// R16 - Boot code may program any page
// R17 - Halting section programming halts the CPU
// R18 - Software avoids concurrent section while busy
// R19 - Boot section always inside halting section
// R20 - Boot fuses split sections, separate locks
// R21 - Programmed bits read zero, unprogrammed one
// R22 - Windows start after write, one pending
`timescale 1ns/1ps
module fspc_top
	import fspc_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire fspc_cpu_s   cpu,
	input  wire fspc_fuse_s  fuses,
	input  wire logic [1:0]  boot_size_fuses,
	input  wire logic        global_irq_flag,
	input  wire logic        eeprom_busy,
	output logic             ready_irq,
	output logic             cpu_halt,
	output logic             lpm_valid,
	output logic      [7:0]  lpm_data,
	output fspc_flash_s      flash
);

	fspc_state_e  state_q;           // Sequencer state
	logic [4:0]   cmd_q;             // Command bits, low five of the register
	logic         irq_en_q;          // Ready interrupt enable
	logic         busy_q;            // Concurrent section blocked
	logic [2:0]   win_q;             // Cycles left in command window
	logic [63:0]  valid_q;           // Buffer word holds stored data
	logic [5:0]   word_q;            // Stream read pointer
	logic         strm_q;            // Read issued last cycle
	logic [5:0]   word_d1_q;         // Word index aligned to read data
	logic [6:0]   page_q;            // Target page of current operation
	logic         halt_tgt_q;        // Target lies in the halting section
	logic [17:0]  prog_cnt_q;        // Programming time left
	logic         pready_q;
	logic [31:0]  prdata_q;
	logic         pslverr_q;
	logic         irq_q;
	logic         halt_q;
	logic         lpm_valid_q;
	logic [7:0]   lpm_data_q;
	fspc_flash_s  flash_q;
	logic [15:0]  rd_data;

	logic         acc;               // APB access phase completing
	logic         hit;               // Address matches the register
	logic         wr_fire;           // Register write takes effect
	logic         legal;             // Written pattern is one of five
	logic         cmd_wr;            // Command accepted into the register
	logic         op_active;         // Erase or write in progress
	logic [6:0]   boot_start;        // First page of the boot section
	logic         in_boot;           // Executing from the boot section
	logic [6:0]   z_page;            // Page addressed by the pointer
	logic         tgt_boot;          // Addressed page is in boot section
	logic         locked;            // Addressed section write-inhibited
	logic         spm_ok;            // Store instruction accepted
	logic         lpm_fuse;          // Load instruction diverted to fuses
	logic         op_start;          // Erase or write begins
	logic         op_done;           // Programming time elapsed
	logic         expire;            // Window runs out this cycle

	localparam logic [17:0] PROG_LOAD = 18'(PROG_CYCLES - 1);

	assign acc     = psel && penable && pready_q;
	assign hit     = (paddr == CSR_ADDR);
	assign wr_fire = acc && pwrite && hit;
	assign op_active = (state_q != ST_IDLE);

	// Pattern filter on the low five bits
	always_comb
	begin
		case (pwdata[4:0])
			CMD_REEN, CMD_FUSE, CMD_PAGE_WRITE_CMD, CMD_PAGE_ERASE_CMD, CMD_FILL: legal = 1'b1; // R13
			default: legal = 1'b0;
		endcase
	end

	// A new command replaces a pending one, but never during an operation
	assign cmd_wr = wr_fire && legal && !op_active; // R13 R22

	// Boot start from fuses, clamped so boot never leaves the halting section
	always_comb
	begin
		case (boot_size_fuses)
			2'b00:   boot_start = BOOT_PAGE_SZ0; // R20
			2'b01:   boot_start = BOOT_PAGE_SZ1;
			2'b10:   boot_start = BOOT_PAGE_SZ2;
			default: boot_start = BOOT_PAGE_SZ3;
		endcase
		if (boot_start < HALTING_SECTION_START_PAGE)
		begin
			boot_start = HALTING_SECTION_START_PAGE; // R19
		end
	end

	assign in_boot  = (cpu.pc_page >= boot_start);
	assign z_page   = cpu.z_addr[13:7];
	assign tgt_boot = (z_page >= boot_start);
	// Each section has its own write inhibit
	assign locked   = tgt_boot ? fuses.lock[LOCK_BOOT_WR] : fuses.lock[LOCK_APP_WR]; // R20

	// Window spans cycles one to four after the write; app stores do nothing
	assign spm_ok   = cpu.spm && cmd_q[BIT_EN] && (win_q != 3'h0) && in_boot
			&& !op_active && !cmd_wr; // R15 R22
	assign lpm_fuse = cpu.lpm && (cmd_q == CMD_FUSE) && (win_q >= WIN_LPM_MIN)
			&& !cmd_wr; // R6
	// Any page, boot included, may be targeted from boot code
	assign op_start = spm_ok && !locked
			&& (cmd_q == CMD_PAGE_ERASE_CMD || cmd_q == CMD_PAGE_WRITE_CMD); // R7 R9 R16
	assign op_done  = (state_q == ST_PROG) && (prog_cnt_q == 18'h00000);
	assign expire   = cmd_q[BIT_EN] && !op_active && (win_q == WIN_LAST)
			&& !spm_ok && !cmd_wr;

	// APB slave: one wait state, then pready for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !hit;
			if (psel && penable && !pready_q && !pwrite && hit)
			begin
				// Reserved bit wired to zero
				prdata_q <= {24'h000000, irq_en_q, busy_q, 1'b0, cmd_q}; // R14 R3
			end
			else
			begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// Interrupt enable follows every register write, legal pattern or not
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_en_q <= CSR_RESET[BIT_IRQ_EN];
		end
		else if (ce && wr_fire)
		begin
			irq_en_q <= pwdata[BIT_IRQ_EN];
		end
	end

	// Command bits: set by write, auto-cleared on use, timeout or op end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_q <= CSR_RESET[4:0];
		end
		else if (ce)
		begin
			if (op_done)
			begin
				cmd_q <= CMD_NONE; // R8 R10 R12
			end
			else if (cmd_wr)
			begin
				cmd_q <= pwdata[4:0]; // R22
			end
			else if (op_start)
			begin
				cmd_q <= cmd_q; // R12
			end
			else if (spm_ok || lpm_fuse || expire)
			begin
				cmd_q <= CMD_NONE; // R8 R10 R12
			end
		end
	end

	// Window counter, loaded at the write so cycle one sees the full count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			win_q <= 3'h0;
		end
		else if (ce)
		begin
			if (cmd_wr)
			begin
				win_q <= WIN_SPM; // R22
			end
			else if (win_q != 3'h0)
			begin
				win_q <= win_q - 3'h1;
			end
		end
	end

	// Valid bits of buffer words; a set and a clear never meet in one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			valid_q <= 64'h0000000000000000;
		end
		else if (ce)
		begin
			if ((wr_fire && legal && !op_active && pwdata[4:0] == CMD_REEN) || op_done)
			begin
				// Buffer lost on re-enable write and spent after an operation
				valid_q <= 64'h0000000000000000; // R5
			end
			else if (spm_ok && cmd_q == CMD_FILL)
			begin
				valid_q[cpu.z_addr[6:1]] <= 1'b1; // R11
			end
		end
	end

	// Section busy: set by a concurrent-section op, cleared by re-enable store
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_q <= 1'b0;
		end
		else if (ce)
		begin
			if (op_start && (z_page < HALTING_SECTION_START_PAGE))
			begin
				busy_q <= 1'b1; // R3
			end
			else if (spm_ok && cmd_q == CMD_REEN)
			begin
				busy_q <= 1'b0; // R3 R4
			end
		end
	end

	// Sequencer for erase and write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q    <= ST_IDLE;
			word_q     <= 6'h00;
			page_q     <= 7'h00;
			halt_tgt_q <= 1'b0;
			prog_cnt_q <= 18'h00000;
		end
		else if (ce)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (op_start)
					begin
						page_q     <= z_page;
						halt_tgt_q <= (z_page >= HALTING_SECTION_START_PAGE); // R17
						word_q     <= 6'h00;
						prog_cnt_q <= PROG_LOAD;
						// Write streams the buffer out first, erase goes straight on
						state_q    <= (cmd_q == CMD_PAGE_WRITE_CMD) ? ST_STREAM : ST_PROG; // R7 R9
					end
				end
				ST_STREAM:
				begin
					word_q <= word_q + 6'h01;
					if (word_q == 6'(PAGE_WORDS - 1))
					begin
						state_q <= ST_PROG;
					end
				end
				ST_PROG:
				begin
					if (prog_cnt_q == 18'h00000)
					begin
						state_q <= ST_IDLE;
					end
					else
					begin
						prog_cnt_q <= prog_cnt_q - 18'h00001;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Flash command stream; data word pair ignored for erase and write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strm_q    <= 1'b0;
			word_d1_q <= 6'h00;
			flash_q   <= '0;
		end
		else if (ce)
		begin
			strm_q           <= (state_q == ST_STREAM);
			word_d1_q        <= word_q;
			flash_q.erase    <= op_start && (cmd_q == CMD_PAGE_ERASE_CMD); // R9
			flash_q.wr_valid <= strm_q; // R7
			flash_q.page     <= op_start ? z_page : page_q;
			flash_q.word     <= word_d1_q;
			// Unfilled words go out erased
			flash_q.data     <= valid_q[word_d1_q] ? rd_data : ERASED_WORD;
		end
	end

	// Halt the CPU only for halting-section operations
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			halt_q <= 1'b0;
		end
		else if (ce)
		begin
			if (op_start)
			begin
				halt_q <= (z_page >= HALTING_SECTION_START_PAGE); // R17
			end
			else if (op_done)
			begin
				halt_q <= 1'b0; // R17
			end
		end
	end

	// Fuse/lock read; stored inverted so programmed reads zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lpm_valid_q <= 1'b0;
			lpm_data_q  <= 8'h00;
		end
		else if (ce)
		begin
			lpm_valid_q <= lpm_fuse; // R6
			if (lpm_fuse)
			begin
				case (cpu.z_addr[1:0])
					2'b00:   lpm_data_q <= ~fuses.fuse_low; // R21
					2'b01:   lpm_data_q <= ~fuses.lock; // R6 R21
					2'b10:   lpm_data_q <= ~fuses.fuse_ext;
					default: lpm_data_q <= ~fuses.fuse_high;
				endcase
			end
		end
	end

	// Ready interrupt while enable is clear and nothing writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_q <= 1'b0;
		end
		else if (ce)
		begin
			irq_q <= irq_en_q && global_irq_flag && !cmd_q[BIT_EN] // R1
					&& !eeprom_busy && !op_active; // R2
		end
	end

	fspc_buf_mem #(
		.WIDTH (WORD_W),
		.DEPTH (PAGE_WORDS),
		.AW    (6)
	) u_buf (
		.pclk      (pclk),
		.ce        (ce),
		.wr_en     (spm_ok && cmd_q == CMD_FILL), // R11
		.wr_addr   (cpu.z_addr[6:1]),
		.wr_data   (cpu.data_word_pair),
		.rd_addr   (word_q),
		.rd_data_q (rd_data)
	);

	assign pready    = pready_q;
	assign prdata    = prdata_q;
	assign pslverr   = pslverr_q;
	assign ready_irq = irq_q;
	assign cpu_halt  = halt_q;
	assign lpm_valid = lpm_valid_q;
	assign lpm_data  = lpm_data_q;
	assign flash     = flash_q;

	// Checks of the register, interrupt, fuse read and sequencer
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	irq_gate_a: assert property (ce && irq_q |-> $past(irq_en_q) && !$past(cmd_q[BIT_EN])) // R1
		else $error("ready irq without enable or with enable bit set");
	irq_quiet_a: assert property (ce && eeprom_busy ##1 ce |-> !irq_q) // R2
		else $error("ready irq during eeprom write");
	busy_set_a: assert property (ce && op_start && z_page < HALTING_SECTION_START_PAGE |=> busy_q) // R3
		else $error("busy not set for concurrent section op");
	buf_clear_a: assert property (ce && cmd_wr && pwdata[4:0] == CMD_REEN |=> valid_q == 64'h0) // R5
		else $error("buffer not cleared by re-enable");
	fuse_read_a: assert property (ce && lpm_fuse && cpu.z_addr[1:0] == 2'b01
			|=> lpm_valid_q && lpm_data_q == ~$past(fuses.lock)) // R6 R21
		else $error("lock byte read wrong");
	write_timeout_a: assert property (ce && cmd_q == CMD_PAGE_WRITE_CMD && expire |=> cmd_q == CMD_NONE) // R8
		else $error("page write bit did not time out");
	erase_timeout_a: assert property (ce && cmd_q == CMD_PAGE_ERASE_CMD && expire |=> cmd_q == CMD_NONE) // R10
		else $error("page erase bit did not time out");
	enable_hold_a: assert property (op_active |-> cmd_q[BIT_EN]) // R12
		else $error("enable dropped during operation");
	illegal_cmd_a: assert property (ce && wr_fire && !legal && cmd_q == CMD_NONE
			&& !op_active |=> cmd_q == CMD_NONE) // R13
		else $error("illegal pattern took effect");
	rsvd_zero_a: assert property (prdata_q[BIT_RSVD] == 1'b0) // R14
		else $error("reserved bit read as one");
	app_store_a: assert property (ce && state_q == ST_IDLE && cpu.spm && !in_boot
			|=> state_q == ST_IDLE) // R15
		else $error("store from application section started op");
	halt_match_a: assert property (halt_q |-> op_active && halt_tgt_q) // R17
		else $error("cpu halted without halting section op");
	boot_halting_section_a: assert property (boot_start >= HALTING_SECTION_START_PAGE) // R19
		else $error("boot section outside halting section");

	erase_c: cover property (ce && op_start && cmd_q == CMD_PAGE_ERASE_CMD);
	write_c: cover property (ce && op_start && cmd_q == CMD_PAGE_WRITE_CMD);
	fuse_c:  cover property (ce && lpm_fuse);
	reen_c:  cover property (ce && busy_q && spm_ok && cmd_q == CMD_REEN);

endmodule

// [fspc_top_tb.sv]
`timescale 1ns/1ps
// Bench: APB control writes, core instructions, flash stream watch
module fspc_top_tb
	import fspc_pkg::*;
;
	localparam int PROG = 20;       // Short programming time keeps the run brief
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        ready_irq, cpu_halt, lpm_valid, global_irq_flag, eeprom_busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  lpm_data, lpm_got;
	logic [1:0]  boot_size_fuses;
	logic [6:0]  er_page, wr_page;
	logic [15:0] wr_mem [0:63];     // Last streamed data per buffer word
	fspc_cpu_s   cpu;
	fspc_fuse_s  fuses;
	fspc_flash_s flash;
	int          n_errors, check_count, n_erase, n_wr, n_lpm;

	// Clock enable tied high: freezing is not exercised here
	fspc_top #(.PROG_CYCLES(PROG)) u_fspc_top (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .cpu(cpu), .fuses(fuses),
		.boot_size_fuses(boot_size_fuses), .global_irq_flag(global_irq_flag),
		.eeprom_busy(eeprom_busy), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
		.lpm_valid(lpm_valid), .lpm_data(lpm_data), .flash(flash));
	fspc_cpu_model u_fspc_cpu_model (.pclk(pclk), .cpu_halt(cpu_halt), .cpu(cpu));

	always #12.5 pclk = ~pclk;

	// Record flash stream and fuse reads as they pass
	always @(posedge pclk)
	begin
		if (flash.erase === 1'b1)
		begin
			n_erase++;
			er_page = flash.page;
		end
		if (flash.wr_valid === 1'b1)
		begin
			n_wr++;
			wr_page = flash.page;
			wr_mem[flash.word] = flash.data;
		end
		if (lpm_valid === 1'b1)
		begin
			n_lpm++;
			lpm_got = lpm_data;
		end
	end

	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, seen, exp);
		end
	endtask

	// One APB transfer; the slave's answer is awaited under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			chk(0, 1, "no pready");
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] v);
		logic [31:0] q;
		logic        e;
		apb(1'b1, CSR_ADDR, {24'h000000, v}, q, e);
	endtask

	task automatic rdchk(input logic [7:0] v, input string m);
		logic [31:0] q;
		logic        e;
		apb(1'b0, CSR_ADDR, 32'h00000000, q, e);
		chk(q, {24'h000000, v}, m);
	endtask

	// Poll the enable bit; it stays up until a running operation ends
	task automatic wait_idle;
		logic [31:0] q;
		logic        e;
		int          n;
		q = 32'h00000001;
		for (n = 0; n < 60 && q[0] !== 1'b0; n++)
			apb(1'b0, CSR_ADDR, 32'h00000000, q, e);
		chk(n < 60, 1, "op never ended");
		// A hung operation ends the run here rather than cascading
		if (n == 60)
		begin
			conclude();
		end
	endtask

	task automatic s_regs;
		logic [31:0] q;
		logic        e;
		rdchk(8'h00, "reset value");
		apb(1'b0, 12'h000, 32'h00000000, q, e);
		chk(q, 32'h00000000, "unmapped read");
		chk(e, 1, "unmapped error");
		wr(8'hFF);
		rdchk(8'h80, "illegal pattern");
		wr(8'h00);
	endtask

	// Fill, discard on re-enable, refill, then write a concurrent page
	task automatic s_fill_write;
		wr(8'h01);
		u_fspc_cpu_model.issue(1'b1, 16'h000F, 16'h1234, 7'h7E, 1);
		rdchk(8'h00, "enable after store");
		wr(8'h11);
		wr(8'h01);
		u_fspc_cpu_model.issue(1'b1, 16'h000B, 16'hA5A5, 7'h7E, 1);
		n_wr = 0;
		wr(8'h05);
		u_fspc_cpu_model.issue(1'b1, 16'h0800, 16'hDEAD, 7'h7E, 4);
		rdchk(8'h45, "busy during write");
		chk(cpu_halt, 0, "halt on concurrent");
		wait_idle();
		chk(n_wr, 64, "word count");
		chk(wr_page, 7'h10, "write page");
		chk(wr_mem[5], 16'hA5A5, "filled word");
		chk(wr_mem[7], 16'hFFFF, "discarded word");
		rdchk(8'h40, "busy after write");
		wr(8'h11);
		u_fspc_cpu_model.issue(1'b1, 16'h0000, 16'h0000, 7'h7E, 1);
		rdchk(8'h00, "busy cleared");
	endtask

	// Erase of the boot page itself halts the core; ready irq follows
	task automatic s_erase;
		global_irq_flag <= 1'b1;
		n_erase = 0;
		wr(8'h83);
		u_fspc_cpu_model.issue(1'b1, 16'h3F00, 16'h0000, 7'h7E, 2);
		repeat (2) @(negedge pclk);
		chk(cpu_halt, 1, "halt on halting page");
		chk(ready_irq, 0, "irq during op");
		chk(n_erase, 1, "erase count");
		chk(er_page, 7'h7E, "erase page");
		wait_idle();
		rdchk(8'h80, "erase bit cleared");
		repeat (2) @(negedge pclk);
		chk({ready_irq, cpu_halt}, 2'b10, "ready irq");
		// Inputs move only on the rising edge
		@(posedge pclk);
		eeprom_busy <= 1'b1;
		repeat (3) @(negedge pclk);
		chk(ready_irq, 0, "irq during eeprom");
		@(posedge pclk);
		eeprom_busy     <= 1'b0;
		global_irq_flag <= 1'b0;
		repeat (3) @(negedge pclk);
		chk(ready_irq, 0, "irq global off");
		wr(8'h00);
	endtask

	// A store in the fifth cycle finds no command left
	task automatic s_timeout;
		logic [7:0] c [2];
		int         i;
		c = '{8'h03, 8'h05};
		for (i = 0; i < 2; i++)
		begin
			n_erase = 0;
			n_wr    = 0;
			wr(c[i]);
			u_fspc_cpu_model.issue(1'b1, 16'h3F00, 16'h0000, 7'h7E, 5);
			rdchk(8'h00, "command timeout");
			chk(n_erase + n_wr, 0, "late store");
		end
	endtask

	// Stores from the application, outside the boot size, or to a locked section
	task automatic s_refuse;
		n_erase = 0;
		wr(8'h03);
		u_fspc_cpu_model.issue(1'b1, 16'h0800, 16'h0000, 7'h10, 1);
		boot_size_fuses <= 2'b11;
		wr(8'h03);
		u_fspc_cpu_model.issue(1'b1, 16'h0800, 16'h0000, 7'h7C, 1);
		boot_size_fuses <= 2'b00;
		fuses.lock      <= 8'h04;
		wr(8'h03);
		u_fspc_cpu_model.issue(1'b1, 16'h0800, 16'h0000, 7'h7C, 1);
		repeat (3) @(negedge pclk);
		chk(n_erase, 0, "refused stores");
		@(posedge pclk);
		fuses.lock <= 8'h00;
	endtask

	// Fuse and lock bytes read inverted; a fourth-cycle load is too late
	task automatic s_fuse;
		logic [7:0] x;
		int         s;
		fuses <= '{8'h5A, 8'hC3, 8'h0F, 8'h24};
		for (s = 0; s < 5; s++)
		begin
			n_lpm = 0;
			x = (s == 0) ? 8'h5A : (s == 1) ? 8'h24 : (s == 2) ? 8'h0F : 8'hC3;
			wr(8'h09);
			u_fspc_cpu_model.issue(1'b0, s[15:0] & 16'h0003, 16'h0000, 7'h7E, (s == 4) ? 4 : 3);
			repeat (2) @(negedge pclk);
			if (s < 4)
			begin
				chk(n_lpm, 1, "fuse read count");
				chk(lpm_got, 8'(~x), "fuse read");
			end
			else
			begin
				chk(n_lpm, 0, "late load");
			end
		end
	endtask

	initial
	begin
		pclk            = 1'b0;
		presetn         = 1'b0;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 12'h000;
		pwdata          = 32'h00000000;
		fuses           = '0;
		boot_size_fuses = 2'b00;
		global_irq_flag = 1'b0;
		eeprom_busy     = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_fill_write();
		s_erase();
		s_timeout();
		s_refuse();
		s_fuse();
		conclude();
	end
endmodule
